// ===== cmc_mode_ctrl.sv
`timescale 1ns/1ps
`include "cmc_defs.svh"
// Summary of operation
// RL1: standby when select high, normal when low
// RL2: normal: low transmit drives bus dominant
// RL3: normal: receive output driven, follows bus
// RL4: standby ignores transmit, drivers off
// RL5: standby releases receive to weak high
// RL6: wake needs dominant, recessive, dominant phases
// RL7: all phases within window or discarded
// RL8: after wake, receive driven and follows bus
// RL9: wake detection is a build option
// RL10: transmit low too long disables drivers
// RL11: drivers stay off until transmit high
// RL12: dominant timeout is a build option
// RL13: overtemperature switches drivers off immediately
// RL14: re-enable needs cool and falling transmit
// RL15: io undervoltage: all pins released, nothing
// RL16: undriven transmit treated high
// RL17: standby pull to ground only if wake-capable
// RL18: main undervoltage forces standby, wake kept
// RL19: permanent dominant never creates persistent wake
// RL20: durations counted on sampling clock
module cmc_mode_ctrl
    import cmc_pkg::*;
#(
    parameter bit        WAKE_EN   = 1'b1,
    parameter bit        TX_DOMINANT_LIMIT_EN  = 1'b1,
    parameter int        FLT1_CYC  = (`CMC_WAKE_FLT1_NS + `CMC_CLK_PERIOD_NS - 1) / `CMC_CLK_PERIOD_NS,
    parameter int        FLT2_CYC  = (`CMC_WAKE_FLT2_NS + `CMC_CLK_PERIOD_NS - 1) / `CMC_CLK_PERIOD_NS,
    parameter int        WTO_CYC   = `CMC_WAKE_TO_NS / `CMC_CLK_PERIOD_NS,
    parameter int        TX_DOMINANT_LIMIT_CYC = (`CMC_TX_DOMINANT_LIMIT_NS + `CMC_CLK_PERIOD_NS - 1) / `CMC_CLK_PERIOD_NS
) (
    // clock, reset, enable
    input  wire logic clk_sys_in,
    input  wire logic rst_in,
    input  wire logic ce_in,
    // controller pins; undriven pins arrive as high from pull-ups
    input  wire logic txd_in,
    input  wire logic standby_select_in,
    output logic      rxd_out,
    output logic      rxd_oe_out,
    // bus receiver and driver
    input  wire logic bus_dominant_in,
    output logic      bus_drive_out,
    output logic      bus_pull_gnd_out,
    output logic      bus_hiz_out,
    // supply and thermal monitors
    input  wire logic overtemp_threshold_in,
    input  wire logic overtemp_cool_in,
    input  wire logic io_supply_undervoltage_in,
    input  wire logic main_supply_undervoltage_in,
    // mode status
    output logic      normal_mode_out,
    output logic      wake_detected_out
);
    localparam logic [15:0] FLT1 = 16'(FLT1_CYC);   // first filter cycles
    localparam logic [15:0] FLT2 = 16'(FLT2_CYC);   // phase filter cycles
    localparam logic [15:0] WTO  = 16'(WTO_CYC);    // wake window cycles
    localparam logic [15:0] TDOM = 16'(TX_DOMINANT_LIMIT_CYC);  // dominant limit cycles

    cmc_state_t s;       // registered state
    cmc_state_t next_s;  // next state

    // synchronised views, second stage only
    logic txd, stb, rxb, hot, cool, viouv, vdduv;
    logic standby;   // effective standby
    logic txd_fall;  // falling edge on transmit
    logic drv_ok;    // drivers permitted
    logic tx_dom;    // wanted dominant, after buffer
    logic buf_in_rdy, buf_out_v;

    always_comb begin
        txd   = s.txd_s[1];
        stb   = s.stb_s[1];
        rxb   = s.rx_s[1];
        hot   = s.ot_s[1];
        cool  = s.otc_s[1];
        viouv = s.vio_s[1];
        vdduv = s.vdd_s[1];
        standby  = stb | vdduv;  // [RL1] [RL18]
        txd_fall = s.txd_prev & ~txd;
        // two-entry buffer carries transmit level to driver stage
        buf_in_rdy = ~s.buf_v[1];
        buf_out_v  = s.buf_v[0];
        tx_dom     = buf_out_v & ~s.buf_d[0];  // undriven high stays recessive [RL16]
        drv_ok     = ~s.dom_lock & ~s.ot_lock & ~hot;
    end

    // next-state logic for the whole block
    always_comb begin
        next_s = s;
        // two-stage synchronisers for every pin input
        next_s.txd_s = {s.txd_s[0], txd_in};
        next_s.stb_s = {s.stb_s[0], standby_select_in};
        next_s.rx_s  = {s.rx_s[0], bus_dominant_in};
        next_s.ot_s  = {s.ot_s[0], overtemp_threshold_in};
        next_s.otc_s = {s.otc_s[0], overtemp_cool_in};
        next_s.vio_s = {s.vio_s[0], io_supply_undervoltage_in};
        next_s.vdd_s = {s.vdd_s[0], main_supply_undervoltage_in};
        next_s.txd_prev = txd;

        // buffer: drain always ready, so never stalls in practice
        if (buf_out_v) begin
            next_s.buf_v = {1'b0, s.buf_v[1]};
            next_s.buf_d = {1'b1, s.buf_d[1]};
        end
        if (buf_in_rdy) begin
            if (next_s.buf_v[0]) begin
                next_s.buf_v[1] = 1'b1;
                next_s.buf_d[1] = txd;
            end else begin
                next_s.buf_v[0] = 1'b1;
                next_s.buf_d[0] = txd;
            end
        end

        // dominant timeout counter on sampling clock [RL20]
        if (txd) begin
            next_s.dom_cnt  = `CMC_TZERO;
            next_s.dom_lock = 1'b0;  // release on high level [RL11]
        end else if (TX_DOMINANT_LIMIT_EN && !standby) begin  // [RL12]
            if (s.dom_cnt >= TDOM) begin
                next_s.dom_lock = 1'b1;  // [RL10]
            end else begin
                next_s.dom_cnt = s.dom_cnt + `CMC_TONE;
            end
        end

        // overtemperature latch; set wins over release
        if (hot) begin
            next_s.ot_lock = 1'b1;  // [RL13]
        end else if (s.ot_lock && cool && txd_fall) begin
            next_s.ot_lock = 1'b0;  // [RL14]
        end

        // wake detector, runs only in standby
        if (!WAKE_EN || !standby || viouv) begin  // [RL9]
            next_s.wake    = WK_IDLE;
            next_s.ph_cnt  = `CMC_TZERO;
            next_s.win_cnt = `CMC_TZERO;
        end else begin
            if (s.wake != WK_IDLE && s.wake != WK_AWAKE) begin
                next_s.win_cnt = s.win_cnt + `CMC_TONE;
            end
            next_s.ph_cnt = s.ph_cnt + `CMC_TONE;
            unique case (s.wake)
                WK_IDLE: begin
                    next_s.ph_cnt  = `CMC_TZERO;
                    next_s.win_cnt = `CMC_TZERO;
                    if (rxb) next_s.wake = WK_DOM1;
                end
                WK_DOM1: begin
                    if (!rxb) begin
                        next_s.ph_cnt = `CMC_TZERO;
                        next_s.wake   = (s.ph_cnt > FLT1) ? WK_REC : WK_IDLE;  // [RL6]
                    end
                end
                WK_REC: begin
                    if (rxb) begin
                        next_s.ph_cnt = `CMC_TZERO;
                        next_s.wake   = (s.ph_cnt > FLT2) ? WK_DOM2 : WK_DOM1;  // [RL6]
                    end
                end
                WK_DOM2: begin
                    if (s.ph_cnt > FLT2) begin
                        next_s.wake = WK_AWAKE;  // [RL6]
                    end else if (!rxb) begin
                        next_s.ph_cnt = `CMC_TZERO;
                        next_s.wake   = WK_REC;
                    end
                end
                WK_AWAKE: begin
                    next_s.ph_cnt = s.ph_cnt;
                end
            endcase
            // window expiry discards sequence; stuck dominant restarts idle [RL7] [RL19]
            if (s.wake != WK_IDLE && s.wake != WK_AWAKE && s.win_cnt >= WTO) begin
                next_s.wake = WK_IDLE;
            end
        end

        // output stage, all registered
        if (viouv) begin
            next_s.outp = '0;  // unpowered: everything released [RL15]
        end else if (standby) begin
            next_s.outp.drive    = 1'b0;  // transmit ignored [RL4] [RL17]
            next_s.outp.pull_gnd = WAKE_EN;  // [RL17]
            if (s.wake == WK_AWAKE) begin
                next_s.outp.rxd_oe  = 1'b1;  // follow bus after wake [RL8]
                next_s.outp.rxd_val = ~rxb;
            end else begin
                next_s.outp.rxd_oe  = 1'b0;  // weak high via pull-up [RL5] [RL9]
                next_s.outp.rxd_val = 1'b1;
            end
        end else begin
            next_s.outp.drive    = tx_dom & drv_ok & ~hot;  // [RL2] [RL10] [RL13]
            next_s.outp.pull_gnd = 1'b0;
            next_s.outp.rxd_oe   = 1'b1;  // [RL3]
            next_s.outp.rxd_val  = ~rxb;  // [RL3]
        end
    end

    // state register with clock enable
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            s <= '{txd_s: 2'h3, stb_s: 2'h3, rx_s: 2'h0, ot_s: 2'h0, otc_s: 2'h0,
                   vio_s: 2'h0, vdd_s: 2'h0, txd_prev: 1'b1, dom_lock: 1'b0, ot_lock: 1'b0,
                   dom_cnt: `CMC_TZERO, ph_cnt: `CMC_TZERO, win_cnt: `CMC_TZERO,
                   wake: WK_IDLE, buf_v: 2'h0, buf_d: 2'h3,
                   outp: '{drive: 1'b0, rxd_val: 1'b1, rxd_oe: 1'b0, pull_gnd: 1'b0}};
        end else if (ce_in) begin
            s <= next_s;
        end
    end

    // outputs
    assign bus_drive_out     = s.outp.drive;
    assign bus_pull_gnd_out  = s.outp.pull_gnd;
    assign rxd_out           = s.outp.rxd_val;
    assign rxd_oe_out        = s.outp.rxd_oe;
    assign bus_hiz_out       = s.vio_s[1];
    assign normal_mode_out   = ~(s.stb_s[1] | s.vdd_s[1]) & ~s.vio_s[1];
    assign wake_detected_out = (s.wake == WK_AWAKE);

    // checks
    chk_standby_no_drive: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ce_in && standby |=> !bus_drive_out) else $error("drive in standby");  // [RL4]
    chk_hot_no_drive: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ce_in && hot |=> !bus_drive_out) else $error("drive while hot");  // [RL13]
    chk_uv_released: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ce_in && viouv |=> !bus_drive_out && !rxd_oe_out && !bus_pull_gnd_out)
        else $error("pins not released");  // [RL15]
    chk_normal_rx_follow: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ce_in && !standby && !viouv |=> rxd_oe_out && (rxd_out == !$past(rxb)))
        else $error("receive not following");  // [RL3]
    chk_standby_rx_idle: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ce_in && standby && !viouv && s.wake != WK_AWAKE |=> !rxd_oe_out && rxd_out)
        else $error("receive not idle");  // [RL5]
    chk_dom_lock_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ce_in && s.dom_lock && !txd |=> s.dom_lock) else $error("lock released early");  // [RL11]
    chk_ot_lock_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ce_in && s.ot_lock && !(cool && txd_fall) |=> s.ot_lock) else $error("ot released early");  // [RL14]
    chk_window_bound: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        s.wake != WK_IDLE && s.wake != WK_AWAKE |-> s.win_cnt <= WTO)
        else $error("window overrun");  // [RL7]
    chk_wake_option: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !WAKE_EN |-> s.wake == WK_IDLE) else $error("wake without option");  // [RL9]
endmodule

// ===== cmc_defs.svh
`ifndef CMC_DEFS_SVH
`define CMC_DEFS_SVH
// sampling clock period in ns
`define CMC_CLK_PERIOD_NS 25
// filter and limit times in ns, defaults only
`define CMC_WAKE_FLT1_NS 1000
`define CMC_WAKE_FLT2_NS 1000
`define CMC_WAKE_TO_NS 100000
`define CMC_TX_DOMINANT_LIMIT_NS 1000000
// timer width
`define CMC_TW 16
`define CMC_TZERO 16'h0000
`define CMC_TONE 16'h0001
`endif

// ===== cmc_pkg.sv
package cmc_pkg;
    // wake detector states
    typedef enum logic [4:0] {
        WK_IDLE = 5'h01,
        WK_DOM1 = 5'h02,
        WK_REC  = 5'h04,
        WK_DOM2 = 5'h08,
        WK_AWAKE = 5'h10
    } cmc_wake_t;
    // bus side outputs
    typedef struct packed {
        logic drive;
        logic rxd_val;
        logic rxd_oe;
        logic pull_gnd;
    } cmc_bus_t;
    // whole module state
    typedef struct packed {
        logic [1:0] txd_s;
        logic [1:0] stb_s;
        logic [1:0] rx_s;
        logic [1:0] ot_s;
        logic [1:0] otc_s;
        logic [1:0] vio_s;
        logic [1:0] vdd_s;
        logic       txd_prev;
        logic       dom_lock;
        logic       ot_lock;
        logic [15:0] dom_cnt;
        logic [15:0] ph_cnt;
        logic [15:0] win_cnt;
        cmc_wake_t  wake;
        logic [1:0] buf_v;
        logic [1:0] buf_d;
        cmc_bus_t   outp;
    } cmc_state_t;
endpackage

// ===== cmc_bus_model.sv
`timescale 1ns/1ps
// two-wire bus seen as one wired-or level: dominant wins over recessive
module cmc_bus_model (
    // this node's driver state and one other node on the bus
    input  wire logic drive_in,
    input  wire logic hiz_in,
    input  wire logic other_dom_in,
    // level reported to the receiver
    output logic      bus_dominant_out
);
    // a released driver adds nothing, so only the other node can pull dominant
    assign bus_dominant_out = (drive_in & ~hiz_in) | other_dom_in;
endmodule

// ===== tb_cmc_mode_ctrl.sv
`timescale 1ns/1ps
module tb_cmc_mode_ctrl;
    import cmc_pkg::*;
    logic clk_sys_in;       // sampling clock
    logic rst_in;           // sync reset
    logic txd_in;           // controller transmit pin
    logic stb_in;           // standby select pin
    logic ot_in;            // above shutdown threshold
    logic cool_in;          // below threshold minus hysteresis
    logic io_supply_undervoltage;           // io supply low
    logic main_supply_undervoltage;           // main supply low
    logic other_dom;        // another node forcing dominant
    logic bus_dom;          // bus level
    logic rxd, rxd_oe, drive, pull, hiz, normal, wake;
    logic ce;               // clock enable
    logic rxd_oe2, drive2, pull2, wake2;  // variant without wake and dominant timeout
    int   fail_count;       // mismatches
    int   checked;          // comparisons
    // small counts keep the run short; ce driven by the test
    cmc_mode_ctrl #(.FLT1_CYC(3), .FLT2_CYC(3), .WTO_CYC(50), .TX_DOMINANT_LIMIT_CYC(30)) cmc_mode_ctrl_i (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce), .txd_in(txd_in),
        .standby_select_in(stb_in), .rxd_out(rxd), .rxd_oe_out(rxd_oe), .bus_dominant_in(bus_dom),
        .bus_drive_out(drive), .bus_pull_gnd_out(pull), .bus_hiz_out(hiz),
        .overtemp_threshold_in(ot_in), .overtemp_cool_in(cool_in),
        .io_supply_undervoltage_in(io_supply_undervoltage), .main_supply_undervoltage_in(main_supply_undervoltage),
        .normal_mode_out(normal), .wake_detected_out(wake));
    // second build: no wake detection, no dominant timeout; listens to the same bus
    cmc_mode_ctrl #(.WAKE_EN(1'b0), .TX_DOMINANT_LIMIT_EN(1'b0), .FLT1_CYC(3), .FLT2_CYC(3), .WTO_CYC(50),
        .TX_DOMINANT_LIMIT_CYC(30)) cmc_mode_ctrl_i2 (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(1'b1), .txd_in(txd_in),
        .standby_select_in(stb_in), .rxd_out(), .rxd_oe_out(rxd_oe2), .bus_dominant_in(bus_dom),
        .bus_drive_out(drive2), .bus_pull_gnd_out(pull2), .bus_hiz_out(),
        .overtemp_threshold_in(ot_in), .overtemp_cool_in(cool_in),
        .io_supply_undervoltage_in(io_supply_undervoltage), .main_supply_undervoltage_in(main_supply_undervoltage),
        .normal_mode_out(), .wake_detected_out(wake2));
    cmc_bus_model cmc_bus_model_i (.drive_in(drive), .hiz_in(hiz), .other_dom_in(other_dom),
        .bus_dominant_out(bus_dom));
    // 40 MHz clock
    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    // compare one output bit
    task automatic chk(input logic seen, input logic exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t mismatch seen %b expected %b", $time, seen, exp);
        end
    endtask
    // pass n falling edges; inputs change only here
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    // verdict and end of run
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        fail_count++;
        stop_test();
    end
    // main sequence; 8 cycles covers sync, output and buffer latency
    initial begin
        fail_count = 0;
        checked = 0;
        rst_in = 1'b1;
        ce = 1'b1;
        txd_in = 1'b1;
        stb_in = 1'b1;
        ot_in = 1'b0;
        cool_in = 1'b1;
        io_supply_undervoltage = 1'b0;
        main_supply_undervoltage = 1'b0;
        other_dom = 1'b0;
        cyc(8);
        rst_in = 1'b0;
        chk(drive, 1'b0); chk(rxd, 1'b1); chk(rxd_oe, 1'b0); chk(normal, 1'b0); chk(hiz, 1'b0);
        // released select pin reads high: standby, drivers off even with txd low
        txd_in = 1'b0;
        cyc(8);
        chk(normal, 1'b0);
        chk(drive, 1'b0);
        chk(rxd_oe, 1'b0); chk(rxd, 1'b1);
        chk(pull, 1'b1);
        chk(pull2, 1'b0);
        // normal mode: transmit low drives dominant, receive follows bus
        txd_in = 1'b1;
        stb_in = 1'b0;
        cyc(8);
        chk(normal, 1'b1); chk(drive, 1'b0); chk(rxd_oe, 1'b1); chk(rxd, 1'b1);
        txd_in = 1'b0;
        cyc(8);
        chk(drive, 1'b1);
        chk(rxd, 1'b0);
        // held low past the limit: drivers cut and stay cut while low
        cyc(40);
        chk(drive, 1'b0); chk(rxd, 1'b1);
        chk(drive2, 1'b1);
        cyc(20);
        chk(drive, 1'b0);
        txd_in = 1'b1;
        cyc(8);
        txd_in = 1'b0;
        cyc(8);
        chk(drive, 1'b1);
        // overtemperature cuts the driver at once
        ot_in = 1'b1;
        cool_in = 1'b0;
        cyc(8);
        chk(drive, 1'b0);
        // falling transmit while still warm is ignored
        ot_in = 1'b0;
        txd_in = 1'b1;
        cyc(8);
        txd_in = 1'b0;
        cyc(8);
        chk(drive, 1'b0);
        // cool plus falling transmit re-enables
        cool_in = 1'b1;
        txd_in = 1'b1;
        cyc(8);
        chk(drive, 1'b0);
        txd_in = 1'b0;
        cyc(8);
        chk(drive, 1'b1);
        // main supply low forces standby
        txd_in = 1'b1;
        main_supply_undervoltage = 1'b1;
        cyc(8);
        chk(normal, 1'b0); chk(rxd_oe, 1'b0); chk(pull, 1'b1);
        // a stuck dominant bus never times the detector into a wake
        other_dom = 1'b1;
        cyc(100);
        chk(wake, 1'b0); chk(rxd_oe, 1'b0); chk(rxd, 1'b1);
        other_dom = 1'b0;
        cyc(60);
        // dominant, recessive, dominant well within the window
        other_dom = 1'b1;
        cyc(8);
        other_dom = 1'b0;
        cyc(8);
        chk(wake, 1'b0);
        other_dom = 1'b1;
        cyc(12);
        chk(wake, 1'b1);
        chk(wake2, 1'b0); chk(rxd_oe2, 1'b0);
        chk(rxd_oe, 1'b1); chk(rxd, 1'b0);
        other_dom = 1'b0;
        cyc(12);
        chk(rxd, 1'b1);
        // io supply low: pins released, nothing sent
        main_supply_undervoltage = 1'b0;
        stb_in = 1'b0;
        io_supply_undervoltage = 1'b1;
        txd_in = 1'b0;
        cyc(8);
        chk(hiz, 1'b1); chk(drive, 1'b0); chk(normal, 1'b0);
        // enable low freezes all state, even the synchronisers
        ce = 1'b0;
        io_supply_undervoltage = 1'b0;
        cyc(8);
        chk(hiz, 1'b1); chk(normal, 1'b0);
        ce = 1'b1;
        cyc(8);
        chk(hiz, 1'b0); chk(normal, 1'b1);
        // second reset mid-run restores idle outputs
        rst_in = 1'b1;
        cyc(2);
        chk(drive, 1'b0); chk(rxd, 1'b1); chk(hiz, 1'b0);
        // release again: select low and transmit low give normal dominant
        rst_in = 1'b0;
        cyc(8);
        chk(normal, 1'b1); chk(drive, 1'b1); chk(rxd_oe, 1'b1);
        stop_test();
    end
endmodule
